// [src/card_reader_map.vh]
// register indices, field positions, reset values and timing counts of the card reader block
`ifndef CARD_READER_MAP_VH
`define CARD_READER_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_CARD_SELECT      4'h0
`define IDX_UART_RECEIVE     4'h5
`define IDX_POWER_CONTROL    4'h7
`define IDX_TIMEOUT_CONFIG   4'h8
`define IDX_TIMEOUT_LOW      4'h9
`define IDX_TIMEOUT_MID      4'ha
`define IDX_TIMEOUT_HIGH     4'hb
`define IDX_FIFO_CONTROL     4'hc
`define IDX_MIXED_STATUS     4'hd
`define IDX_UART_STATUS      4'he
`define IDX_HW_STATUS        4'hf

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_UART_RESET_N     3
`define BIT_SESSION_START    0
`define BIT_SHUTDOWN_REQ     7
`define BIT_PROT_LATCH       5
`define BIT_SUPERVISOR       4
`define BIT_PRESENCE         2
`define BIT_OVERHEAT         0
`define HSR_IRQ_BITS         8'ha5
`define TOC_MODE24           0
`define TOC_MODE_A_LSB       1
`define TOC_MODE_B_LSB       3
`define FCR_DEPTH_LSB        0
`define FCR_RETRY_LSB        4
`define FCR_BUF_MASK         7
`define USR_BUFFER           0
`define USR_TIMEOUT_A        1
`define USR_TIMEOUT_B        2

// ----------------------------------------------------------------
// counter start modes
// ----------------------------------------------------------------
`define START_STOPPED        2'h0
`define START_ON_WRITE       2'h1
`define START_ON_START_BIT   2'h2
`define START_AUTO_RELOAD    2'h3

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define RST_BYTE             8'h00
`define RST_WORD             32'h0000_0000
`define POR_DELAY_NS         2000
`define CLK_MHZ              50
`define POR_DELAY_CYCLES     ((`POR_DELAY_NS * `CLK_MHZ) / 1000)

`endif

// [src/etu_down_counter.v]
// one etu time-out down counter with selectable start mode
`timescale 1ns/1ps
`default_nettype none
`include "card_reader_map.vh"

module etu_down_counter
(
  input  wire        clk_in,
  input  wire        resetn_in,
  input  wire        clear_in,
  input  wire        etu_tick_in,
  input  wire        start_bit_in,
  input  wire        load_in,
  input  wire [1:0]  mode_in,
  input  wire [23:0] value_in,
  output reg         expire_out
);

  reg  [23:0] count_q;
  reg         run_q;
  reg         armed_q;

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      count_q    <= 24'h00_0000;
      run_q      <= 1'b0;
      armed_q    <= 1'b0;
      expire_out <= 1'b0;
    end
    else
    begin
      expire_out <= 1'b0;
      if (clear_in)
      begin
        count_q <= 24'h00_0000;
        run_q   <= 1'b0;
        armed_q <= 1'b0;
      end
      else if (load_in)
      begin
        count_q <= value_in;
        run_q   <= (mode_in == `START_ON_WRITE) || (mode_in == `START_AUTO_RELOAD);
        armed_q <= (mode_in == `START_ON_START_BIT);
      end
      else if (armed_q && start_bit_in)
      begin
        run_q   <= 1'b1;
        armed_q <= 1'b0;
        count_q <= value_in;
      end
      else if (run_q && etu_tick_in)
      begin
        if (count_q <= 24'h00_0001)
        begin
          expire_out <= 1'b1;
          if (mode_in == `START_AUTO_RELOAD)
            count_q <= value_in;
          else
          begin
            count_q <= 24'h00_0000;
            run_q   <= 1'b0;
          end
        end
        else
          count_q <= count_q - 24'h00_0001;
      end
    end
  end

endmodule
`default_nettype wire

// [src/card_reader_status_control.v]
// card reader control and status registers behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "card_reader_map.vh"

module card_reader_status_control
(
  input  wire        CLK_SYS_IN,
  input  wire        RESETN_IN,
  input  wire        HSEL_IN,
  input  wire [31:0] HADDR_IN,
  input  wire [1:0]  HTRANS_IN,
  input  wire        HWRITE_IN,
  input  wire [2:0]  HSIZE_IN,
  input  wire [31:0] HWDATA_IN,
  input  wire        HREADY_IN,
  output reg  [31:0] HRDATA_OUT,
  output reg         HREADYOUT_OUT,
  output reg         HRESP_OUT,
  input  wire        SHUTDOWN_PIN_N_IN,
  input  wire        VCC_PROT_FAULT_IN,
  input  wire        RST_PROT_FAULT_IN,
  input  wire        SUPPLY_DROP_IN,
  input  wire        CARD_PRESENT_IN,
  input  wire        OVERHEAT_IN,
  input  wire        ETU_TICK_IN,
  input  wire        START_BIT_IN,
  input  wire        RX_VALID_IN,
  input  wire [7:0]  RX_DATA_IN,
  output reg         IRQ_N_OUT,
  output reg         UART_RESET_N_OUT,
  output reg         SESSION_START_OUT,
  output reg  [2:0]  RETRANSMIT_LIMIT_OUT
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg         uart_reset_n_bit_q, session_start_q, present_q, por_active_q;
  reg         usr_clear_q, wr_pend_q, toc_load_q;
  reg  [7:0]  timeout_config_q, timeout_low_q, timeout_mid_q, timeout_high_q;
  reg  [7:0]  fifo_control_q, hardware_status_q, rd_mux;
  reg  [7:0]  clr_mask0_q, clr_mask1_q, clr_mask2_q;
  reg  [2:0]  uart_status_q, wr_ptr_q, rd_ptr_q;
  reg  [3:0]  wr_idx_q, fill_q;
  reg  [15:0] por_count_q;
  wire [63:0] rx_flat;
  wire        expire_a, expire_b;
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire       accept   = HSEL_IN & HREADY_IN & HTRANS_IN[1] & (HSIZE_IN == 3'h2);
  wire       in_range = (HADDR_IN[31:6] == 26'h0) & (HADDR_IN[1:0] == 2'h0);
  wire [3:0] idx      = HADDR_IN[5:2];
  wire       rd_hit   = accept & ~HWRITE_IN & in_range;
  wire       wr_data  = wr_pend_q;
  wire [7:0] wbyte    = HWDATA_IN[7:0];
  wire       uart_held = ~uart_reset_n_bit_q;
  // ----------------------------------------------------------------
  // hardware events
  // ----------------------------------------------------------------
  wire prot_event   = VCC_PROT_FAULT_IN | RST_PROT_FAULT_IN;
  wire supervisor_latch_event   = SUPPLY_DROP_IN | por_active_q;
  wire pres_event   = CARD_PRESENT_IN ^ present_q;
  wire heat_event   = OVERHEAT_IN;
  wire shut_event   = ~SHUTDOWN_PIN_N_IN;
  wire [7:0] hsr_set = {shut_event, 1'b0, prot_event, supervisor_latch_event,
                        1'b0, pres_event, 1'b0, heat_event};
  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------
  wire [3:0] depth    = {1'b0, fifo_control_q[`FCR_DEPTH_LSB +: 3]} + 4'h1;
  wire       push     = RX_VALID_IN & ~uart_held & (fill_q < depth);
  wire       pop      = rd_hit & (idx == `IDX_UART_RECEIVE) & (fill_q != 4'h0);
  wire       buf_flag = (fill_q >= depth);

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : rx_entry
      localparam [31:0] SLOT = g;
      reg [7:0] byte_q;
      always @(posedge CLK_SYS_IN or negedge RESETN_IN)
      begin
        if (!RESETN_IN)
          byte_q <= `RST_BYTE;
        else if (push && (wr_ptr_q == SLOT[2:0]))
          byte_q <= RX_DATA_IN;
      end
      assign rx_flat[g*8 +: 8] = byte_q;
    end
  endgenerate

  always @(posedge CLK_SYS_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      wr_ptr_q <= 3'h0;
      rd_ptr_q <= 3'h0;
      fill_q   <= 4'h0;
    end
    else if (uart_held)
    begin
      wr_ptr_q <= 3'h0;
      rd_ptr_q <= 3'h0;
      fill_q   <= 4'h0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 3'h1;
      if (pop)
        rd_ptr_q <= rd_ptr_q + 3'h1;
      if (push && !pop)
        fill_q <= fill_q + 4'h1;
      else if (pop && !push)
        fill_q <= fill_q - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // time-out counters
  // ----------------------------------------------------------------
  wire        mode24  = timeout_config_q[`TOC_MODE24];
  wire [23:0] value_a = mode24 ? {timeout_high_q, timeout_mid_q, timeout_low_q}
                               : {8'h00, timeout_high_q, timeout_mid_q};
  wire [1:0]  mode_b  = mode24 ? `START_STOPPED
                               : timeout_config_q[`TOC_MODE_B_LSB +: 2];
  etu_down_counter counter_a
  (
    .clk_in       (CLK_SYS_IN),
    .resetn_in    (RESETN_IN),
    .clear_in     (uart_held),
    .etu_tick_in  (ETU_TICK_IN),
    .start_bit_in (START_BIT_IN),
    .load_in      (toc_load_q),
    .mode_in      (timeout_config_q[`TOC_MODE_A_LSB +: 2]),
    .value_in     (value_a),
    .expire_out   (expire_a)
  );
  etu_down_counter counter_b
  (
    .clk_in       (CLK_SYS_IN),
    .resetn_in    (RESETN_IN),
    .clear_in     (uart_held),
    .etu_tick_in  (ETU_TICK_IN),
    .start_bit_in (START_BIT_IN),
    .load_in      (toc_load_q),
    .mode_in      (mode_b),
    .value_in     ({16'h0000, timeout_low_q}),
    .expire_out   (expire_b)
  );
  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @*
  begin
    rd_mux = 8'h00;
    if (idx == `IDX_CARD_SELECT)
      rd_mux[`BIT_UART_RESET_N] = uart_reset_n_bit_q;
    else if (idx == `IDX_UART_RECEIVE)
      rd_mux = rx_flat[{rd_ptr_q, 3'h0} +: 8];
    else if (idx == `IDX_POWER_CONTROL)
      rd_mux[`BIT_SESSION_START] = session_start_q;
    else if (idx == `IDX_TIMEOUT_CONFIG)
      rd_mux = timeout_config_q;
    else if (idx == `IDX_FIFO_CONTROL)
      rd_mux = fifo_control_q;
    else if (idx == `IDX_MIXED_STATUS)
      rd_mux = {4'h0, uart_reset_n_bit_q, buf_flag, fill_q == 4'h0, present_q};
    else if (idx == `IDX_UART_STATUS)
      rd_mux = {5'h00, uart_status_q};
    else if (idx == `IDX_HW_STATUS)
      rd_mux = hardware_status_q;
  end

  // ----------------------------------------------------------------
  // bus slave and software registers
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      HRDATA_OUT         <= `RST_WORD;
      HREADYOUT_OUT      <= 1'b1;
      HRESP_OUT          <= 1'b0;
      wr_pend_q          <= 1'b0;
      wr_idx_q           <= 4'h0;
      toc_load_q         <= 1'b0;
      uart_reset_n_bit_q <= 1'b0;
      session_start_q    <= 1'b0;
      timeout_config_q   <= `RST_BYTE;
      timeout_low_q      <= `RST_BYTE;
      timeout_mid_q      <= `RST_BYTE;
      timeout_high_q     <= `RST_BYTE;
      fifo_control_q     <= `RST_BYTE;
    end
    else
    begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
      wr_pend_q     <= accept & HWRITE_IN & in_range;
      wr_idx_q      <= idx;
      HRDATA_OUT    <= rd_hit ? {24'h00_0000, rd_mux} : `RST_WORD;
      toc_load_q    <= wr_data && (wr_idx_q == `IDX_TIMEOUT_CONFIG) && !uart_held;
      if (wr_data && (wr_idx_q == `IDX_CARD_SELECT))
        uart_reset_n_bit_q <= wbyte[`BIT_UART_RESET_N];
      // a protection fault, supervisor event, presence change or overheat overrides a software start in the same cycle
      if (prot_event || supervisor_latch_event || pres_event || heat_event)
        session_start_q <= 1'b0;
      else if (wr_data && (wr_idx_q == `IDX_POWER_CONTROL))
        session_start_q <= wbyte[`BIT_SESSION_START];
      if (uart_held)
      begin
        timeout_config_q <= `RST_BYTE;
        timeout_low_q    <= `RST_BYTE;
        timeout_mid_q    <= `RST_BYTE;
        timeout_high_q   <= `RST_BYTE;
        fifo_control_q   <= `RST_BYTE;
      end
      else if (wr_data)
      begin
        if (wr_idx_q == `IDX_TIMEOUT_CONFIG)
          timeout_config_q <= wbyte;
        else if (wr_idx_q == `IDX_TIMEOUT_LOW)
          timeout_low_q <= wbyte;
        else if (wr_idx_q == `IDX_TIMEOUT_MID)
          timeout_mid_q <= wbyte;
        else if (wr_idx_q == `IDX_TIMEOUT_HIGH)
          timeout_high_q <= wbyte;
        else if (wr_idx_q == `IDX_FIFO_CONTROL)
          fifo_control_q <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // status latches and read-clear pipeline
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      hardware_status_q <= `RST_BYTE;
      present_q         <= 1'b0;
      por_count_q       <= 16'h0000;
      por_active_q      <= 1'b1;
      clr_mask0_q       <= 8'h00;
      clr_mask1_q       <= 8'h00;
      clr_mask2_q       <= 8'h00;
      uart_status_q     <= 3'h0;
      usr_clear_q       <= 1'b0;
    end
    else
    begin
      present_q <= CARD_PRESENT_IN;
      if ({16'h0000, por_count_q} == (`POR_DELAY_CYCLES - 1))
        por_active_q <= 1'b0;
      else
        por_count_q <= por_count_q + 16'h0001;
      // snapshot at the address phase; the strobe ends one edge later and
      // the clear lands two edges after that
      clr_mask0_q <= (rd_hit && (idx == `IDX_HW_STATUS)) ? hardware_status_q : 8'h00;
      clr_mask1_q <= clr_mask0_q;
      clr_mask2_q <= clr_mask1_q;
      hardware_status_q <= (hardware_status_q & ~(clr_mask2_q &
                           {3'h7, ~por_active_q, 4'hf})) | hsr_set;
      usr_clear_q <= rd_hit && (idx == `IDX_UART_STATUS);
      if (uart_held)
        uart_status_q <= 3'h0;
      else
      begin
        uart_status_q[`USR_BUFFER]    <= buf_flag;
        uart_status_q[`USR_TIMEOUT_A] <= (uart_status_q[`USR_TIMEOUT_A] & ~usr_clear_q)
                                         | expire_a;
        uart_status_q[`USR_TIMEOUT_B] <= (uart_status_q[`USR_TIMEOUT_B] & ~usr_clear_q)
                                         | expire_b;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // mixed status is deliberately absent from the interrupt term
  wire usr_irq = (uart_status_q[`USR_BUFFER] & ~fifo_control_q[`FCR_BUF_MASK])
               | uart_status_q[`USR_TIMEOUT_A] | uart_status_q[`USR_TIMEOUT_B];
  wire hsr_irq = |(hardware_status_q & `HSR_IRQ_BITS);
  always @(posedge CLK_SYS_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      IRQ_N_OUT            <= 1'b1;
      UART_RESET_N_OUT     <= 1'b0;
      SESSION_START_OUT    <= 1'b0;
      RETRANSMIT_LIMIT_OUT <= 3'h0;
    end
    else
    begin
      IRQ_N_OUT            <= ~(hsr_irq | usr_irq);
      UART_RESET_N_OUT     <= uart_reset_n_bit_q;
      SESSION_START_OUT    <= session_start_q;
      RETRANSMIT_LIMIT_OUT <= fifo_control_q[`FCR_RETRY_LSB +: 3];
    end
  end

endmodule
`default_nettype wire

// [verif/card_side_model.sv]
// behavioural card side: faults, presence, etu ticks, characters
`timescale 1ns/1ps
`default_nettype none
module card_side_model
(
  input  wire logic       clk_in,
  input  wire logic [2:0] kind_in,
  input  wire logic       hold_in,
  input  wire logic [7:0] char_in,
  output logic            shutdown_n_out,
  output logic            vcc_fault_out,
  output logic            rst_fault_out,
  output logic            drop_out,
  output logic            present_out,
  output logic            overheat_out,
  output logic            tick_out,
  output logic            start_bit_out,
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out
);
  logic [1:0] div_q = 2'h0;
  logic       hold_q = 1'b0;
  logic       pres_q = 1'b0;
  logic [2:0] pulse_q = 3'h0;
  logic [7:0] data_q = 8'h5a;
  wire logic  rise = hold_in && !hold_q;
  // levels follow the hold for as long as it lasts
  assign shutdown_n_out = !(hold_in && kind_in == 3'h0);
  assign vcc_fault_out  = hold_in && kind_in == 3'h1;
  assign rst_fault_out  = hold_in && kind_in == 3'h2;
  assign overheat_out   = hold_in && kind_in == 3'h4;
  assign drop_out       = hold_in && kind_in == 3'h5;
  assign present_out    = pres_q;
  assign {start_bit_out, rx_valid_out, tick_out} = pulse_q;
  assign rx_data_out    = data_q;
  always @(posedge clk_in)
  begin
    div_q   <= div_q + 2'h1;
    hold_q  <= hold_in;
    pulse_q <= {rise && kind_in == 3'h7, rise && kind_in == 3'h6, div_q == 2'h3};
    if (rise && kind_in == 3'h3)
      pres_q <= !pres_q;
    // off-frame the data wanders so a stale byte never passes as fresh
    data_q  <= (rise && kind_in == 3'h6) ? char_in : ~data_q;
  end
endmodule
`default_nettype wire

// [verif/card_reader_status_control_chk.sv]
// port assertions of the card reader status block
`timescale 1ns/1ps
`default_nettype none
module card_reader_status_control_chk
(
  input wire logic        CLK_SYS_IN,
  input wire logic        RESETN_IN,
  input wire logic        HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0]  HTRANS_IN,
  input wire logic        HWRITE_IN,
  input wire logic [2:0]  HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic        HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  input wire logic        SHUTDOWN_PIN_N_IN,
  input wire logic        VCC_PROT_FAULT_IN,
  input wire logic        RST_PROT_FAULT_IN,
  input wire logic        SUPPLY_DROP_IN,
  input wire logic        CARD_PRESENT_IN,
  input wire logic        OVERHEAT_IN,
  input wire logic        IRQ_N_OUT,
  input wire logic        UART_RESET_N_OUT,
  input wire logic        SESSION_START_OUT,
  input wire logic [2:0]  RETRANSMIT_LIMIT_OUT
);
  wire logic acc = HSEL_IN && HREADY_IN && HTRANS_IN[1] && HSIZE_IN == 3'h2;
  wire logic rd = acc && !HWRITE_IN;
  wire logic wr = acc && HWRITE_IN;
  wire logic fault = VCC_PROT_FAULT_IN || RST_PROT_FAULT_IN;
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RESETN_IN);
  a_shutdown_irq:
    assert property (!SHUTDOWN_PIN_N_IN |-> ##[1:4] !IRQ_N_OUT)
    else $error("no interrupt on shutdown");
  a_fault_irq:
    assert property (fault |-> ##[1:4] !IRQ_N_OUT)
    else $error("no interrupt on fault");
  a_heat_irq:
    assert property (OVERHEAT_IN |-> ##[1:4] !IRQ_N_OUT)
    else $error("no interrupt on overheat");
  a_presence_irq:
    assert property (CARD_PRESENT_IN != $past(CARD_PRESENT_IN) |-> ##[1:4] !IRQ_N_OUT)
    else $error("no interrupt on presence change");
  a_session_drop:
    assert property (SESSION_START_OUT && (fault || SUPPLY_DROP_IN || OVERHEAT_IN
      || CARD_PRESENT_IN != $past(CARD_PRESENT_IN)) |-> ##[1:3] !SESSION_START_OUT)
    else $error("session kept after emergency");
  a_bus_okay:
    assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("wait state or error response");
  a_rdata_phase:
    assert property (HRDATA_OUT != 32'h0 |-> $past(rd))
    else $error("read data outside data phase");
  a_select_unused:
    assert property (rd && HADDR_IN == 32'h0 |=> (HRDATA_OUT & ~32'h8) == 32'h0)
    else $error("unused select bits set");
  a_status_unused:
    assert property (rd && HADDR_IN == 32'h3c |=> (HRDATA_OUT & ~32'hb5) == 32'h0)
    else $error("unused status bits set");
  a_uart_reset:
    assert property (wr && HADDR_IN == 32'h0 |-> ##3 UART_RESET_N_OUT == $past(HWDATA_IN[3], 2))
    else $error("uart reset output wrong");
  a_retry_limit:
    assert property (wr && HADDR_IN == 32'h30 && UART_RESET_N_OUT
      |-> ##3 RETRANSMIT_LIMIT_OUT == $past(HWDATA_IN[6:4], 2))
    else $error("retry limit wrong");
endmodule
bind card_reader_status_control card_reader_status_control_chk i_chk
(
  .CLK_SYS_IN, .RESETN_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN, .HWRITE_IN, .HSIZE_IN,
  .HWDATA_IN, .HREADY_IN, .HRDATA_OUT, .HREADYOUT_OUT, .HRESP_OUT, .SHUTDOWN_PIN_N_IN,
  .VCC_PROT_FAULT_IN, .RST_PROT_FAULT_IN, .SUPPLY_DROP_IN, .CARD_PRESENT_IN, .OVERHEAT_IN,
  .IRQ_N_OUT, .UART_RESET_N_OUT, .SESSION_START_OUT, .RETRANSMIT_LIMIT_OUT
);
`default_nettype wire

// [verif/card_reader_status_control_bench.sv]
// self-checking bench of the card reader status and control block
`timescale 1ns/1ps
`default_nettype none
module card_reader_status_control_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  kind = 3'h0;
  logic        hold = 1'b0;
  logic [7:0]  chr = 8'h0;
  logic [31:0] r;
  logic [31:0] w;
  logic [7:0]  timeout_config [4] = '{8'h03, 8'h08, 8'h05, 8'h07};
  integer      seed = 32'h3c6283f3;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  wire logic [31:0] hrdata;
  wire logic [2:0]  retry;
  wire logic [7:0]  rxd;
  wire logic hready, hresp, irq_n, uart_rst_n, session;
  wire logic sd_n, vcc_f, rst_f, drop, pres, heat, tick, sbit, rxv;
  card_reader_status_control i_dut
  (
    .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .SHUTDOWN_PIN_N_IN(sd_n), .VCC_PROT_FAULT_IN(vcc_f), .RST_PROT_FAULT_IN(rst_f),
    .SUPPLY_DROP_IN(drop), .CARD_PRESENT_IN(pres), .OVERHEAT_IN(heat),
    .ETU_TICK_IN(tick), .START_BIT_IN(sbit), .RX_VALID_IN(rxv), .RX_DATA_IN(rxd),
    .IRQ_N_OUT(irq_n), .UART_RESET_N_OUT(uart_rst_n), .SESSION_START_OUT(session),
    .RETRANSMIT_LIMIT_OUT(retry)
  );
  card_side_model i_card
  (
    .clk_in(clk), .kind_in(kind), .hold_in(hold), .char_in(chr), .shutdown_n_out(sd_n),
    .vcc_fault_out(vcc_f), .rst_fault_out(rst_f), .drop_out(drop), .present_out(pres),
    .overheat_out(heat), .tick_out(tick), .start_bit_out(sbit), .rx_valid_out(rxv),
    .rx_data_out(rxd)
  );
  always #10 clk = ~clk;
  // ------
  // checking and bus tasks
  // ------
  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // entered just after an edge; holds each phase until hready is seen
  task automatic bus(input logic [31:0] a, input logic wt, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wt;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    r = hrdata;
  endtask
  task automatic fire(input logic [2:0] k, input int n);
    kind <= k;
    hold <= 1'b1;
    idle(n);
    hold <= 1'b0;
  endtask
  function automatic logic [31:0] hsr_bit(input logic [2:0] k);
    case (k)
      3'h0: hsr_bit = 32'h80;
      3'h1, 3'h2: hsr_bit = 32'h20;
      3'h3: hsr_bit = 32'h04;
      3'h4: hsr_bit = 32'h01;
      default: hsr_bit = 32'h10;
    endcase
  endfunction
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      miscompares = miscompares + 1;
      results();
    end
  end
  // ------
  // scenarios
  // ------
  initial
  begin
    idle(20);
    rst_n <= 1'b1;
    idle(1);
    for (int i = 0; i < 3; i++)
    begin
      bus(32'h3c, 1'b0, 32'h0);
      chk(r, 32'h10);
      idle(i == 1 ? 110 : 4);
    end
    bus(32'h3c, 1'b0, 32'h0);
    chk(r, 32'h0);
    bus(32'h0, 1'b0, 32'h0);
    chk(r, 32'h0);
    chk_pin(uart_rst_n, 1'b0);
    $display("test power-on done");
    for (int i = 0; i < 4; i++)
    begin
      w = $random(seed);
      bus(32'h0, 1'b1, w);
      bus(32'h0, 1'b0, 32'h0);
      chk(r, w & 32'h8);
      idle(1);
      chk_pin(uart_rst_n, w[3]);
    end
    bus(32'h4, 1'b1, 32'hff);
    bus(32'h4, 1'b0, 32'h0);
    chk(r, 32'h0);
    bus(32'h0, 1'b1, 32'h0);
    bus(32'h0, 1'b1, 32'h8);
    $display("test select done");
    for (int k = 0; k < 6; k++)
    begin
      bus(32'h1c, 1'b1, 32'h1);
      fire(k[2:0], 3);
      idle(4);
      chk_pin(irq_n, (hsr_bit(k[2:0]) & 32'ha5) == 32'h0);
      bus(32'h3c, 1'b0, 32'h0);
      chk(r, hsr_bit(k[2:0]));
      chk_pin(session, k == 0);
      if (k == 0)
        bus(32'h1c, 1'b1, 32'h0);
      idle(4);
      bus(32'h3c, 1'b0, 32'h0);
      chk(r, 32'h0);
      chk_pin(irq_n, 1'b1);
      chk_pin(session, 1'b0);
    end
    kind <= 3'h4;
    hold <= 1'b1;
    idle(2);
    bus(32'h3c, 1'b0, 32'h0);
    idle(4);
    hold <= 1'b0;
    idle(1);
    bus(32'h3c, 1'b0, 32'h0);
    chk(r, 32'h01);
    $display("test status done");
    w = $random(seed);
    bus(32'h30, 1'b1, {24'h0, 1'b1, w[6:4], 4'h0});
    idle(2);
    chk({29'h0, retry}, {29'h0, w[6:4]});
    for (int m = 0; m < 2; m++)
    begin
      chr <= 8'($random(seed));
      fire(3'h6, 1);
      idle(4);
      chk_pin(irq_n, m == 0);
      bus(32'h14, 1'b0, 32'h0);
      chk(r, {24'h0, chr});
      bus(32'h30, 1'b1, 32'h0);
    end
    bus(32'h34, 1'b0, 32'h0);
    chk(r, 32'h0b);
    $display("test fifo done");
    bus(32'h24, 1'b1, 32'h3);
    for (int t = 0; t < 4; t++)
    begin
      bus(32'h20, 1'b1, {24'h0, timeout_config[t]});
      if (t == 2)
      begin
        idle(40);
        chk_pin(irq_n, 1'b1);
        fire(3'h7, 1);
      end
      idle(40);
      chk_pin(irq_n, 1'b0);
      if (t == 3)
      begin
        // auto-reload must expire again after the status is cleared
        bus(32'h38, 1'b0, 32'h0);
        chk(r, 32'h2);
        idle(20);
        chk_pin(irq_n, 1'b0);
      end
      bus(32'h20, 1'b1, 32'h0);
      bus(32'h38, 1'b0, 32'h0);
      chk(r, t == 1 ? 32'h4 : 32'h2);
      idle(4);
    end
    $display("test timeout done");
    results();
  end
endmodule
`default_nettype wire
